/* hdl/uhcs_buf2.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uhcs_params.svh"

module uhcs_buf2 #(
    parameter int WIDTH = `UHCS_DATA_W,
    parameter int DEPTH = `UHCS_BUF_DEPTH
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_flush,
    input wire logic i_valid,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_ready,
    output logic o_valid,
    output logic [WIDTH-1:0] o_data,
    input wire logic i_ready
);
    if (DEPTH != 2) begin : g_bad_depth
        $error("uhcs_buf2 supports two entries only");
    end
    if (WIDTH < 1) begin : g_bad_width
        $error("uhcs_buf2 width must be positive");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic wr_q, wr_d, rd_q, rd_d;
    logic [1:0] cnt_q, cnt_d;
    logic push, pop;

    assign o_ready = (cnt_q != 2'd2);
    assign o_valid = (cnt_q != 2'd0);
    assign o_data = mem_q[rd_q];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    always_comb begin
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (i_flush) begin
            wr_d = 1'b0;
            rd_d = 1'b0;
            cnt_d = 2'd0;
        end else begin
            if (push) begin
                mem_d[wr_q] = i_data;
                wr_d = ~wr_q;
            end
            if (pop) begin
                rd_d = ~rd_q;
            end
            cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= 2'd0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            mem_q <= mem_d;
        end
    end

    a_buf_no_overflow: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        cnt_q <= 2'd2) else $error("buffer count above two");
    a_buf_stall_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (o_valid && !i_ready && !i_flush) |=> (o_valid && $stable(o_data)))
        else $error("stalled word lost or changed");

endmodule : uhcs_buf2
`default_nettype wire

/* hdl/uhcs_params.svh */
`ifndef UHCS_PARAMS_SVH
`define UHCS_PARAMS_SVH

// ****************************************
// clock figures
// ****************************************
`define UHCS_SYS_CLK_MHZ 200
`define UHCS_REF_CLK_MHZ 48
`define UHCS_LS_RATE_KBPS 1500
`define UHCS_FS_RATE_KBPS 12000

// ****************************************
// sequencer and reference timeout counts, in system clock cycles
// ****************************************
`define UHCS_SETTLE_CYC 4
`define UHCS_INTRST_CYC 16
`define UHCS_REF_TIMEOUT_CYC 8

// ****************************************
// widths and structure
// ****************************************
`define UHCS_NUM_PORTS 1
`define UHCS_DATA_W 32
`define UHCS_BUF_DEPTH 2
`define UHCS_CNT_W 8

`endif

/* hdl/uhcs_pkg.sv */
package uhcs_pkg;

    // ****************************************
    // bring-up sequencer states
    // ****************************************
    typedef enum logic [1:0] {
        UHCS_OFF = 2'b00,
        UHCS_CLKON = 2'b01,
        UHCS_INIT = 2'b10,
        UHCS_READY = 2'b11
    } uhcs_state_t;

    typedef enum logic {
        UHCS_REF_PLL = 1'b0,
        UHCS_REF_EXT = 1'b1
    } uhcs_ref_sel_t;

endpackage : uhcs_pkg

/* hdl/uhcs_shell.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uhcs_params.svh"

module uhcs_shell
    import uhcs_pkg::*;
#(
    parameter int NUM_PORTS = `UHCS_NUM_PORTS,
    parameter int DATA_W = `UHCS_DATA_W,
    parameter int SETTLE_CYC = `UHCS_SETTLE_CYC,
    parameter int INTRST_CYC = `UHCS_INTRST_CYC,
    parameter int REF_TIMEOUT_CYC = `UHCS_REF_TIMEOUT_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_slot_clk_en,
    input wire logic i_slot_rst_rel,
    input wire logic i_ref_sel,
    input wire logic i_ref_pll_clk,
    input wire logic i_usb_ref_clock_input,
    input wire logic i_hs_phy_on,
    input wire logic i_core_irq,
    input wire logic i_mem_valid,
    input wire logic [DATA_W-1:0] i_mem_data,
    output logic o_mem_ready,
    output logic o_core_valid,
    output logic [DATA_W-1:0] o_core_data,
    input wire logic i_core_ready,
    output logic o_core_clk_gate_en,
    output logic o_core_rst,
    output logic o_ref_sel,
    output logic o_ref_ok,
    output logic o_irq_proc_a,
    output logic o_irq_proc_b,
    output logic o_ready
);
    // ****************************************
    // elaboration checks
    // ****************************************
    if (NUM_PORTS != 1) begin : g_bad_ports
        $error("only one downstream port is served");
    end
    if (`UHCS_FS_RATE_KBPS != 8 * `UHCS_LS_RATE_KBPS) begin : g_bad_rates
        $error("speed ratio");
    end
    // refuse counts the 8-bit counters cannot hold
    if (SETTLE_CYC < 1 || SETTLE_CYC > 255) begin : g_bad_settle
        $error("SETTLE_CYC out of range");
    end
    if (INTRST_CYC < 1 || INTRST_CYC > 255) begin : g_bad_intrst
        $error("INTRST_CYC out of range");
    end
    if (REF_TIMEOUT_CYC < 2 || REF_TIMEOUT_CYC > 255) begin : g_bad_ref_to
        $error("REF_TIMEOUT_CYC range");
    end
    // ref must toggle at least twice per timeout window
    if (`UHCS_REF_CLK_MHZ * REF_TIMEOUT_CYC < `UHCS_SYS_CLK_MHZ) begin : g_bad_window
        $error("timeout short");
    end

    localparam logic [`UHCS_CNT_W-1:0] SETTLE_LAST = `UHCS_CNT_W'(SETTLE_CYC - 1);
    localparam logic [`UHCS_CNT_W-1:0] INTRST_LAST = `UHCS_CNT_W'(INTRST_CYC - 1);
    localparam logic [`UHCS_CNT_W-1:0] REF_TO = `UHCS_CNT_W'(REF_TIMEOUT_CYC);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [2:0] sync1_q, sync2_q;
    logic ref_prev_q;
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else begin
            sync1_q <= {i_hs_phy_on, i_usb_ref_clock_input, i_ref_pll_clk};
            sync2_q <= sync1_q;
        end
    end

    // ****************************************
    // reference clock presence
    // ****************************************
    logic ref_lvl, ref_prev_d, ref_sel_q, ref_sel_d;
    logic [`UHCS_CNT_W-1:0] ref_cnt_q, ref_cnt_d;
    logic ref_ok;

    // pll source counts only while the companion phy is up
    assign ref_lvl = ref_sel_q ? sync2_q[1] : (sync2_q[0] & sync2_q[2]);
    assign ref_ok = (ref_cnt_q < REF_TO);

    always_comb begin
        ref_sel_d = i_ref_sel;
        ref_prev_d = ref_lvl;
        ref_cnt_d = ref_cnt_q;
        if (ref_lvl != ref_prev_q || ref_sel_d != ref_sel_q) begin
            ref_cnt_d = '0;
        end else if (ref_cnt_q < REF_TO) begin
            ref_cnt_d = ref_cnt_q + `UHCS_CNT_W'(1);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            ref_sel_q <= 1'b0;
            ref_prev_q <= 1'b0;
            ref_cnt_q <= REF_TO;
        end else begin
            ref_sel_q <= ref_sel_d;
            ref_prev_q <= ref_prev_d;
            ref_cnt_q <= ref_cnt_d;
        end
    end

    // ****************************************
    // release latch and bring-up sequencer
    // ****************************************
    uhcs_state_t st_q, st_d;
    logic [`UHCS_CNT_W-1:0] cnt_q, cnt_d;
    logic hold_q, hold_d, rel_prev_q, rel_prev_d;
    logic slot_go;

    // release counts only as a fresh low-to-high step after device reset
    always_comb begin
        rel_prev_d = i_slot_rst_rel;
        hold_d = hold_q;
        if (i_slot_rst_rel && !rel_prev_q) begin
            hold_d = 1'b0;
        end
    end

    assign slot_go = i_slot_clk_en && i_slot_rst_rel && !hold_q;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        case (st_q)
            UHCS_OFF: begin
                cnt_d = '0;
                if (slot_go) begin
                    st_d = UHCS_CLKON;
                end
            end
            UHCS_CLKON: begin
                cnt_d = cnt_q + `UHCS_CNT_W'(1);
                if (cnt_q == SETTLE_LAST) begin
                    st_d = UHCS_INIT;
                    cnt_d = '0;
                end
            end
            UHCS_INIT: begin
                cnt_d = cnt_q + `UHCS_CNT_W'(1);
                if (cnt_q == INTRST_LAST) begin
                    st_d = UHCS_READY;
                    cnt_d = '0;
                end
            end
            UHCS_READY: begin
                cnt_d = '0;
            end
            default: begin
                st_d = UHCS_OFF;
                cnt_d = '0;
            end
        endcase
        // slot may drop clock or reset at any step
        if (!slot_go) begin
            st_d = UHCS_OFF;
            cnt_d = '0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            st_q <= UHCS_OFF;
            cnt_q <= '0;
            hold_q <= 1'b1;
            rel_prev_q <= 1'b1;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            hold_q <= hold_d;
            rel_prev_q <= rel_prev_d;
        end
    end

    // ****************************************
    // outputs to the core
    // ****************************************
    logic gate_q, core_rst_q, irq_q, ready_q;
    logic gate_d, core_rst_d, irq_d, ready_d;
    // flopped, so the core never sees a glitch on its gate or reset
    always_comb begin
        gate_d = (st_d != UHCS_OFF);
        core_rst_d = (st_d == UHCS_OFF) || (st_d == UHCS_CLKON);
        irq_d = i_core_irq && (st_q == UHCS_READY);
        ready_d = (st_d == UHCS_READY) && ref_ok;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            gate_q <= 1'b0;
            core_rst_q <= 1'b1;
            irq_q <= 1'b0;
            ready_q <= 1'b0;
        end else begin
            gate_q <= gate_d;
            core_rst_q <= core_rst_d;
            irq_q <= irq_d;
            ready_q <= ready_d;
        end
    end

    assign o_core_clk_gate_en = gate_q;
    assign o_core_rst = core_rst_q;
    assign o_ref_sel = ref_sel_q;
    assign o_ref_ok = ref_ok;
    assign o_irq_proc_a = irq_q;
    assign o_irq_proc_b = irq_q;
    assign o_ready = ready_q;

    // ****************************************
    // bus master data path
    // ****************************************
    logic buf_ready;
    uhcs_buf2 #(
        .WIDTH(DATA_W),
        .DEPTH(`UHCS_BUF_DEPTH)
    ) u_buf (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        // flush on the edge that enters reset, so no stale word is shown in reset
        .i_flush(core_rst_d),
        .i_valid(i_mem_valid && ready_q),
        .i_data(i_mem_data),
        .o_ready(buf_ready),
        .o_valid(o_core_valid),
        .o_data(o_core_data),
        .i_ready(i_core_ready)
    );
    // no word is taken while the core is in reset
    assign o_mem_ready = buf_ready && ready_q;

    // ****************************************
    // checks
    // ****************************************
    a_rel_needs_clock: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        $fell(o_core_rst) |-> $past(o_core_clk_gate_en, 4))
        else $error("reset released before clock settled");
    a_ready_after_init: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        $rose(o_ready) |-> $past(!o_core_rst, 16))
        else $error("ready before internal reset time");
    a_slot_drop_off: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !i_slot_clk_en |=> (!o_core_clk_gate_en && o_core_rst))
        else $error("slot drop did not stop core");
    a_reset_holds: assert property (@(posedge i_sys_clk)
        $fell(i_rst) |-> (o_core_rst && !o_core_clk_gate_en))
        else $error("core left reset without release");
    a_hold_until_rel: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (hold_q && !(i_slot_rst_rel && !rel_prev_q)) |=> o_core_rst)
        else $error("reset released without fresh release");
    a_irq_both: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        $rose(o_irq_proc_a) |-> ($past(i_core_irq) && o_irq_proc_b))
        else $error("interrupt not delivered to both cores");
    a_no_data_rst: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_core_rst |-> (!o_mem_ready && !o_core_valid))
        else $error("data moves during core reset");
    a_ref_lost: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (st_q == UHCS_READY && !o_ref_ok) |=> !o_ready)
        else $error("ready without reference clock");
    a_irq_off_outside: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (st_q != UHCS_READY) |=> !o_irq_proc_a)
        else $error("interrupt outside ready state");
    a_ready_needs_gate: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_ready |-> (o_core_clk_gate_en && !o_core_rst))
        else $error("ready without running core");
    a_mem_ready_gated: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_mem_ready |-> o_ready)
        else $error("word taken before bring-up done");
    a_rst_follows_gate: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !o_core_clk_gate_en |-> o_core_rst)
        else $error("reset released with clock gated");
    a_rst_not_ready: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_core_rst |-> !o_ready)
        else $error("ready while core in reset");

endmodule : uhcs_shell
`default_nettype wire

/* verification/tb_usb_host_clock_reset_shell.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    $display("unexpected %s exp %h got %h", nm, e, g); miscompares++; end end
module tb_usb_host_clock_reset_shell;
    import uhcs_pkg::*;
    localparam int SETTLE = 4;
    localparam int INTRST = 16;
    typedef struct packed {logic sel; logic phy; logic ext; logic pll; logic ok;} uhcs_row_t;
    uhcs_row_t rows [6] = '{5'b10101, 5'b10000, 5'b01011, 5'b00010, 5'b01000, 5'b10101};
    logic clk, rst, clk_en, rel, ref_sel, hs_on, irq, mv, cr, run_ext, run_pll, stall, slow;
    logic ext_clk, pll_clk, mr, ov, gate, core_rst, rsel, ok, irq_a, irq_b, rdy;
    logic [31:0] md, od, exp_w;
    logic [31:0] exp_q [$];
    int miscompares = 0;
    int n_checks = 0;
    int cyc = 0;
    uhcs_shell #(.SETTLE_CYC(SETTLE), .INTRST_CYC(INTRST), .REF_TIMEOUT_CYC(8)) DUT (
        .i_sys_clk(clk), .i_rst(rst), .i_slot_clk_en(clk_en), .i_slot_rst_rel(rel),
        .i_ref_sel(ref_sel), .i_ref_pll_clk(pll_clk), .i_usb_ref_clock_input(ext_clk),
        .i_hs_phy_on(hs_on), .i_core_irq(irq), .i_mem_valid(mv), .i_mem_data(md),
        .o_mem_ready(mr), .o_core_valid(ov), .o_core_data(od), .i_core_ready(cr),
        .o_core_clk_gate_en(gate), .o_core_rst(core_rst), .o_ref_sel(rsel),
        .o_ref_ok(ok), .o_irq_proc_a(irq_a), .o_irq_proc_b(irq_b), .o_ready(rdy));
    uhcs_partner far_side (.i_sys_clk(clk), .i_run_ext(run_ext), .i_run_pll(run_pll),
        .i_stall(stall), .i_slow(slow), .o_ext_clk(ext_clk), .o_pll_clk(pll_clk),
        .o_ready(cr));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic step;
        @(posedge clk);
    endtask : step
    task automatic end_sim;
        if (miscompares == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    // hang guard, well above the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            end_sim();
        end
    end
    always @(posedge clk) begin
        if (ov === 1'b1 && cr === 1'b1) begin
            exp_w = exp_q.pop_front();
            `CHK("core_data", exp_w, od)
        end
    end
    task automatic bring_up;
        int n;
        step;
        rel <= 1'b0;
        step;
        rel <= 1'b1;
        n = 0;
        do begin step; #1; n++; end while (gate !== 1'b1 && n < 10);
        `CHK("gate_en", 1'b1, gate)
        n = 0;
        do begin step; #1; n++; end while (core_rst !== 1'b0 && n < 100);
        `CHK("settle", SETTLE, n)
        n = 0;
        do begin step; #1; n++; end while (rdy !== 1'b1 && n < 100);
        `CHK("intrst", INTRST, n)
    endtask : bring_up
    // holds valid across accepted words, so words go back to back
    task automatic burst(input int cnt);
        int t;
        step;
        mv <= 1'b1;
        md <= {16'hbeef, 16'h0000};
        for (int i = 0; i < cnt; i++) begin
            t = 0;
            do begin step; t++; end while (mr !== 1'b1 && t < 100);
            exp_q.push_back(md);
            if (i == cnt - 1)
                mv <= 1'b0;
            else
                md <= {16'hbeef, 16'(i + 1)};
        end
    endtask : burst
    task automatic drain;
        int t;
        t = 0;
        while (exp_q.size() != 0 && t < 60) begin step; t++; end
        step;
        #1;
        `CHK("core_valid", 1'b0, ov)
        `CHK("left", 0, exp_q.size())
    endtask : drain
    initial begin
        rst = 1'b1; clk_en = 1'b1; rel = 1'b1; ref_sel = 1'b1; hs_on = 1'b0; irq = 1'b1;
        mv = 1'b0; md = '0; run_ext = 1'b1; run_pll = 1'b0; stall = 1'b0; slow = 1'b0;
        repeat (20) step;
        #1;
        `CHK("gate_en", 1'b0, gate)
        `CHK("core_rst", 1'b1, core_rst)
        `CHK("irq_a", 1'b0, irq_a)
        `CHK("mem_ready", 1'b0, mr)
        step;
        rst <= 1'b0;
        irq <= 1'b0;
        foreach (rows[i]) begin
            step;
            {ref_sel, hs_on, run_ext, run_pll} <= rows[i][4:1];
            repeat (24) step;
            #1;
            `CHK("ref_ok", rows[i].ok, ok)
            `CHK("ref_sel", rows[i].sel, rsel)
        end
        `CHK("gate_held", 1'b0, gate)
        bring_up();
        step;
        irq <= 1'b1;
        step;
        #1;
        `CHK("irq_a", 1'b1, irq_a)
        `CHK("irq_b", 1'b1, irq_b)
        step;
        irq <= 1'b0;
        step;
        #1;
        `CHK("irq_b", 1'b0, irq_b)
        stall <= 1'b1;
        fork
            burst(5);
            begin
                repeat (12) step;
                #1;
                `CHK("mem_ready", 1'b0, mr)
                `CHK("core_valid", 1'b1, ov)
                step;
                stall <= 1'b0;
                slow <= 1'b1;
            end
        join
        drain();
        slow <= 1'b0;
        burst(4);
        drain();
        step;
        run_ext <= 1'b0;
        repeat (20) step;
        #1;
        `CHK("ref_ok", 1'b0, ok)
        `CHK("ready", 1'b0, rdy)
        step;
        run_ext <= 1'b1;
        repeat (20) step;
        rel <= 1'b0;
        repeat (2) step;
        #1;
        `CHK("gate_en", 1'b0, gate)
        `CHK("core_rst", 1'b1, core_rst)
        bring_up();
        stall <= 1'b1;
        burst(2);
        clk_en <= 1'b0;
        repeat (2) step;
        #1;
        `CHK("gate_en", 1'b0, gate)
        `CHK("core_rst", 1'b1, core_rst)
        `CHK("core_valid", 1'b0, ov)
        exp_q.delete();
        step;
        stall <= 1'b0;
        clk_en <= 1'b1;
        repeat (2) step;
        #1;
        `CHK("gate_back", 1'b1, gate)
        step;
        rst <= 1'b1;
        repeat (3) step;
        #1;
        `CHK("core_rst", 1'b1, core_rst)
        `CHK("ready", 1'b0, rdy)
        step;
        rst <= 1'b0;
        repeat (5) step;
        #1;
        `CHK("gate_held", 1'b0, gate)
        end_sim();
    end
endmodule : tb_usb_host_clock_reset_shell
`default_nettype wire

/* verification/uhcs_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// far side: 48 mhz references and a core-side sink
// ****************************************
module uhcs_partner (
    input wire logic i_sys_clk,
    input wire logic i_run_ext,
    input wire logic i_run_pll,
    input wire logic i_stall,
    input wire logic i_slow,
    output logic o_ext_clk,
    output logic o_pll_clk,
    output logic o_ready
);
    logic ph = 1'b0;
    // a stopped reference stands still, as a dead oscillator would
    initial begin
        o_ext_clk = 1'b0;
        forever #10.417 if (i_run_ext) o_ext_clk = ~o_ext_clk;
    end
    initial begin
        o_pll_clk = 1'b0;
        #3.1;
        forever #10.417 if (i_run_pll) o_pll_clk = ~o_pll_clk;
    end
    // slow mode takes a word at most every other cycle
    always @(posedge i_sys_clk) begin
        ph <= ~ph;
        o_ready <= ~i_stall & (ph | ~i_slow);
    end
endmodule : uhcs_partner
`default_nettype wire
